/* hw/bsg_supervisor.sv */
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ps
// Contract
// R01 - high gate supply at load, low at light
// R02 - sample zero crossing at low-side falling edge
// R03 - go low after 256 consecutive crossings
// R04 - missed crossing clears count, selects high
// R05 - converter turn-on starts at high supply
// R06 - enable low holds supply at low level
// R07 - flag high only inside sense window
// R08 - hysteresis on lower window threshold
// R09 - flag pin open drain, external pull-up
// R10 - enable low forces flag low
// R11 - trip after qualification delay above threshold
// R12 - trip latches high side off, flag low
// R13 - low side on while sense above trip
// R14 - high-side latch cleared only by power-on
// R15 - over-voltage logic works regardless of enable
// R16 - skipped pulse enters braking, low side off
// R17 - no braking during pre-biased start-up
// R18 - over-voltage latch overrides braking, low side on
// R19 - enable low turns both drives off; low side stays on while the over-voltage trip is set
// R20 - synchronise all asynchronous inputs
// R21 - delay counted on reference clock, dip restarts
module bsg_supervisor (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic enable_i,
  input wire logic zero_cross_cmp_i,
  input wire logic sense_above_trip_i,
  input wire logic sense_above_pg_hi_i,
  input wire logic sense_above_pg_lo_i,
  input wire logic hs_pwm_i,
  input wire logic ls_pwm_i,
  input wire logic pulse_skip_i,
  input wire logic prebias_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic high_side_drive_o,
  output logic low_side_drive_o,
  output logic gate_supply_high_o,
  output logic output_in_regulation_flag_o,
  output logic output_in_regulation_flag_oe_o,
  output logic overvoltage_trip_o
);
  import bsg_pkg::*;

  typedef struct packed {
    logic [bsg_pkg::IN_W-1:0] s1;
    logic [bsg_pkg::IN_W-1:0] s2;
    logic [bsg_pkg::IN_W-1:0] s3;
    logic [bsg_pkg::IN_W-1:0] in;
    logic en_d;
    logic [1:0] ctrl;
    logic [8:0] zc_cnt;
    logic supply_high;
    logic in_reg;
    logic [6:0] ov_cnt;
    logic ov_trip;
    logic hs_latch;
    logic braking;
    logic hs;
    logic ls;
    logic [31:0] rdata;
  } bsg_state_t;

  bsg_state_t st_ff;
  bsg_state_t nxt_st;
  logic [IN_W-1:0] nxt_in;
  logic [31:0] status_w;

  //////////////////////////////////////////////////////////////////////////////
  // input filter: change accepted once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < IN_W; gi++) begin : g_filt
      assign nxt_in[gi] = (st_ff.s2[gi] == st_ff.s3[gi]) ? st_ff.s3[gi] : st_ff.in[gi]; // [R20]
    end
  endgenerate

  assign status_w = {25'h0000000, st_ff.in[IN_PREBIAS], st_ff.in[IN_EN], st_ff.braking,
                     st_ff.hs_latch, st_ff.ov_trip, st_ff.in_reg, st_ff.supply_high};

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic en;
    logic ov;
    logic ls_fall;
    logic brake_req;
    en = 1'b0;
    ov = 1'b0;
    ls_fall = 1'b0;
    brake_req = 1'b0;
    nxt_st = st_ff;
    nxt_st.s1 = {prebias_i, pulse_skip_i, ls_pwm_i, hs_pwm_i, sense_above_pg_lo_i,
                 sense_above_pg_hi_i, sense_above_trip_i, zero_cross_cmp_i, enable_i}; // [R20]
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    nxt_st.in = nxt_in;
    en = st_ff.in[IN_EN];
    ov = st_ff.in[IN_OV];
    nxt_st.en_d = en;

    // over-voltage qualification, enable not involved
    if (!ov) begin
      nxt_st.ov_cnt = 7'h00; // [R21] [R15]
      nxt_st.ov_trip = 1'b0; // [R13]
    end else if (st_ff.ov_cnt < OVP_CYC) begin
      nxt_st.ov_cnt = st_ff.ov_cnt + 7'h01; // [R21]
    end else begin
      nxt_st.ov_trip = 1'b1; // [R11]
      nxt_st.hs_latch = 1'b1; // [R12] [R14]
    end

    // in-regulation window with lower hysteresis
    if (!st_ff.in[IN_PG_LO] || ov) begin
      nxt_st.in_reg = 1'b0; // [R07] [R08]
    end else if (st_ff.in[IN_PG_HI]) begin
      nxt_st.in_reg = 1'b1; // [R07] [R08]
    end

    // braking on skipped pulse
    brake_req = st_ff.ctrl[CTRL_BRAKE_EN] && st_ff.in[IN_SKIP] && !st_ff.in[IN_PREBIAS];
    nxt_st.braking = en && brake_req && !st_ff.hs_latch; // [R16] [R17] [R18]

    // drive outputs
    nxt_st.hs = en && !nxt_st.hs_latch && !nxt_st.braking && st_ff.in[IN_HS_PWM]; // [R12] [R19]
    if (nxt_st.ov_trip) begin
      nxt_st.ls = 1'b1; // [R13] [R18]
    end else begin
      nxt_st.ls = en && !nxt_st.braking && st_ff.in[IN_LS_PWM]; // [R16] [R19]
    end

    // gate supply selection; needs the next low-side level, so it follows the drives
    ls_fall = st_ff.ls && !nxt_st.ls;
    if (!en) begin
      nxt_st.zc_cnt = 9'h000;
      nxt_st.supply_high = 1'b0; // [R06]
    end else if (!st_ff.en_d) begin
      nxt_st.zc_cnt = 9'h000;
      nxt_st.supply_high = 1'b1; // [R05]
    end else if (st_ff.ctrl[CTRL_FORCE_HIGH]) begin
      nxt_st.zc_cnt = 9'h000;
      nxt_st.supply_high = 1'b1; // [R01]
    end else if (ls_fall) begin // [R02]
      if (!st_ff.in[IN_ZC]) begin
        nxt_st.zc_cnt = 9'h000; // [R04]
        nxt_st.supply_high = 1'b1; // [R04]
      end else if (st_ff.zc_cnt < ZC_CYCLES - 9'h001) begin
        nxt_st.zc_cnt = st_ff.zc_cnt + 9'h001;
      end else begin
        nxt_st.zc_cnt = ZC_CYCLES;
        nxt_st.supply_high = 1'b0; // [R03] [R01]
      end
    end

    // register port
    if (wr_i && addr_i == ADDR_CTRL) begin
      nxt_st.ctrl = wdata_i[1:0];
    end
    nxt_st.rdata = 32'h0000_0000;
    if (rd_i) begin
      case (addr_i)
        ADDR_CTRL: nxt_st.rdata = {30'h00000000, st_ff.ctrl};
        ADDR_STATUS: nxt_st.rdata = status_w;
        ADDR_ZC_COUNT: nxt_st.rdata = {23'h000000, st_ff.zc_cnt};
        default: nxt_st.rdata = RD_UNMAPPED;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_ff <= '0;
      st_ff.ctrl <= CTRL_RST;
      st_ff.s1 <= IN_RST;
      st_ff.s2 <= IN_RST;
      st_ff.s3 <= IN_RST;
      st_ff.in <= IN_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  assign rdata_o = st_ff.rdata;
  assign high_side_drive_o = st_ff.hs;
  assign low_side_drive_o = st_ff.ls;
  assign gate_supply_high_o = st_ff.supply_high;
  assign overvoltage_trip_o = st_ff.ov_trip;
  // pin only ever pulled low; released means high via external pull-up
  assign output_in_regulation_flag_o = 1'b0; // [R09]
  assign output_in_regulation_flag_oe_o =
    !(st_ff.in_reg && st_ff.in[IN_EN] && !st_ff.hs_latch); // [R10] [R12] [R09]
endmodule : bsg_supervisor

/* hw/bsg_pkg.sv */
package bsg_pkg;
  // input bit positions in the synchroniser vector
  localparam int IN_W = 9;
  localparam int IN_EN = 0;
  localparam int IN_ZC = 1;
  localparam int IN_OV = 2;
  localparam int IN_PG_HI = 3;
  localparam int IN_PG_LO = 4;
  localparam int IN_HS_PWM = 5;
  localparam int IN_LS_PWM = 6;
  localparam int IN_SKIP = 7;
  localparam int IN_PREBIAS = 8;
  localparam logic [IN_W-1:0] IN_RST = 9'h000;

  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int OVP_DELAY_NS = 2500;
  localparam int OVP_CYC_INT = (OVP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0] OVP_CYC = 7'(OVP_CYC_INT);
  localparam logic [8:0] ZC_CYCLES = 9'h100;

  // register map, byte addresses
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_ZC_COUNT = 4'h8;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

  // control fields
  localparam int CTRL_BRAKE_EN = 0;
  localparam int CTRL_FORCE_HIGH = 1;
  localparam logic [1:0] CTRL_RST = 2'h1;

  // status fields
  localparam int ST_SUPPLY_HIGH = 0;
  localparam int ST_IN_REG = 1;
  localparam int ST_OV_TRIP = 2;
  localparam int ST_HS_LATCH = 3;
  localparam int ST_BRAKING = 4;
  localparam int ST_ENABLE = 5;
  localparam int ST_PREBIAS = 6;
endpackage : bsg_pkg

/* tb/bsg_monitor.sv */
`timescale 1ns/1ps
module bsg_monitor (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic enable_i,
  input wire logic sense_above_trip_i,
  input wire logic high_side_drive_o,
  input wire logic low_side_drive_o,
  input wire logic gate_supply_high_o,
  input wire logic output_in_regulation_flag_o,
  input wire logic output_in_regulation_flag_oe_o,
  input wire logic overvoltage_trip_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence en_off; !enable_i [*6]; endsequence
  sequence en_rise; !enable_i ##1 enable_i [*6]; endsequence
  a_trip_hs_off: assert property (overvoltage_trip_o |-> !high_side_drive_o)
    else $error("high side on in trip");
  a_trip_ls_on: assert property (overvoltage_trip_o |-> low_side_drive_o)
    else $error("low side off in trip");
  a_flag_never_high: assert property (!output_in_regulation_flag_o)
    else $error("flag pin driven high");
  a_trip_qual: assert property ($rose(overvoltage_trip_o) |-> $past(sense_above_trip_i, 30))
    else $error("trip too early");
  a_trip_clear: assert property (!sense_above_trip_i [*4] |-> ##2 !overvoltage_trip_o)
    else $error("trip held after dip");
  a_en_off_flag: assert property (en_off |-> output_in_regulation_flag_oe_o)
    else $error("flag released, enable low");
  a_en_off_sup: assert property (en_off |-> !gate_supply_high_o)
    else $error("supply high, enable low");
  a_en_rise_sup: assert property (en_rise |-> gate_supply_high_o)
    else $error("supply low after turn-on");
endmodule : bsg_monitor
bind bsg_supervisor bsg_monitor u_mon (.*);

/* tb/bsg_stage.sv */
`timescale 1ns/1ps
module bsg_stage (
  input wire logic clk_i,
  input wire logic light_i,
  output logic hs_o,
  output logic ls_o,
  output logic zc_o
);
  logic [2:0] ph_ff = 3'h0;
  initial {hs_o, ls_o, zc_o} = 3'h0;
  always @(posedge clk_i) begin
    ph_ff <= ph_ff + 3'h1;
    hs_o <= ph_ff < 3'h3;
    ls_o <= ph_ff > 3'h3;
    zc_o <= light_i; // current reverses at light load
  end
endmodule : bsg_stage

/* tb/test_bsg_supervisor.sv */
`timescale 1ns/1ps
module test_bsg_supervisor;
  import bsg_pkg::*;
  logic clk = 0, rst_n = 0, en = 0, ot = 0, ph = 0, pl = 0, sk = 0, pb = 0, lt = 0;
  logic wr = 0, rd = 0, hs, ls, zc, hsd, lsd, sup, fl, oe, trip, v;
  logic [3:0] ad = 4'h0;
  logic [31:0] wd = 32'h0, rdat;
  int error_cnt = 0, n_tests = 0, cyc = 0, i;
  wire pin = oe ? fl : 1'b1; // external pull-up
  initial forever #25 clk = ~clk;
  always @(posedge clk) if (++cyc > 9000) begin error_cnt++; close_out(); end
  bsg_stage u_stg (.clk_i(clk), .light_i(lt), .hs_o(hs), .ls_o(ls), .zc_o(zc));
  bsg_supervisor uut (.ref_clk_i(clk), .reset_n_i(rst_n), .enable_i(en),
    .zero_cross_cmp_i(zc), .sense_above_trip_i(ot), .sense_above_pg_hi_i(ph),
    .sense_above_pg_lo_i(pl), .hs_pwm_i(hs), .ls_pwm_i(ls), .pulse_skip_i(sk),
    .prebias_i(pb), .addr_i(ad), .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdat),
    .high_side_drive_o(hsd), .low_side_drive_o(lsd), .gate_supply_high_o(sup),
    .output_in_regulation_flag_o(fl), .output_in_regulation_flag_oe_o(oe),
    .overvoltage_trip_o(trip));
  //////////////////////////////////////////////////////////////////////////////
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask : tk
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s exp %0h got %0h", n, e, s);
    end
  endtask : chk
  task automatic sw(input logic e, input logic m);
    v = 0;
    repeat (8) begin tk(1); v = v | hsd | (lsd & m); end
    chk("drive activity", e, v);
  endtask : sw
  task automatic rdreg(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk) begin ad <= a; rd <= 1; end
    @(posedge clk) rd <= 0;
    #5 chk("rdata", e, rdat);
  endtask : rdreg
  task automatic wrreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk) begin ad <= a; wd <= d; wr <= 1; end
    @(posedge clk) wr <= 0;
  endtask : wrreg
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_rst();
    tk(1);
    chk("pin", 0, pin);
    chk("sup", 0, sup);
    rdreg(ADDR_CTRL, 32'(CTRL_RST));
    rdreg(4'hC, RD_UNMAPPED);
  endtask : t_rst
  task automatic t_flag();
    @(posedge clk) {en, ph, pl} <= 3'h7;
    tk(6);
    chk("sup", 1, sup);
    chk("pin", 1, pin);
    @(posedge clk) ph <= 0;
    tk(6);
    chk("pin", 1, pin);
    @(posedge clk) pl <= 0;
    tk(6);
    chk("pin", 0, pin);
    @(posedge clk) {en, ph, pl} <= 3'h3;
    tk(6);
    chk("pin", 0, pin);
    sw(0, 1);
  endtask : t_flag
  task automatic t_zc();
    @(posedge clk) {en, lt} <= 2'h3;
    tk(1920);
    chk("sup", 1, sup);
    for (i = 0; i < 200 && sup === 1'b1; i++) tk(1);
    chk("sup", 0, sup);
    rdreg(ADDR_ZC_COUNT, 32'(ZC_CYCLES));
    wrreg(ADDR_CTRL, 32'(CTRL_RST) | 32'(1 << CTRL_FORCE_HIGH));
    tk(2);
    chk("sup", 1, sup);
    wrreg(ADDR_CTRL, 32'(CTRL_RST));
    for (i = 0; i < 2200 && sup === 1'b1; i++) tk(1);
    chk("sup", 0, sup);
    @(posedge clk) lt <= 0;
    tk(8);
    @(posedge clk) lt <= 1;
    tk(6);
    chk("sup", 1, sup);
    tk(200);
    chk("sup", 1, sup);
  endtask : t_zc
  task automatic t_brk();
    @(posedge clk) sk <= 1;
    tk(6);
    sw(0, 1);
    @(posedge clk) pb <= 1;
    tk(6);
    sw(1, 1);
    @(posedge clk) pb <= 0;
    wrreg(ADDR_CTRL, 32'h0);
    tk(6);
    sw(1, 1);
    wrreg(ADDR_CTRL, 32'(CTRL_RST));
  endtask : t_brk
  task automatic t_ovp();
    @(posedge clk) ot <= 1;
    tk(30);
    chk("trip", 0, trip);
    for (i = 0; i < 60 && trip !== 1'b1; i++) tk(1);
    chk("trip", 1, trip);
    chk("drv", 1, {hsd, lsd});
    chk("pin", 0, pin);
    @(posedge clk) en <= 0;
    tk(6);
    chk("ls", 1, lsd);
    rdreg(ADDR_STATUS, 32'(1 << ST_OV_TRIP) | 32'(1 << ST_HS_LATCH));
    @(posedge clk) {en, ot, sk} <= 3'h4;
    tk(6);
    chk("trip", 0, trip);
    chk("pin", 0, pin);
    sw(0, 0);
    @(posedge clk) rst_n <= 0;
    @(posedge clk) rst_n <= 1;
    tk(6);
    sw(1, 0);
    chk("pin", 1, pin);
  endtask : t_ovp
  task automatic close_out();
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1;
    t_rst();
    t_flag();
    t_zc();
    t_brk();
    t_ovp();
    close_out();
  end
endmodule : test_bsg_supervisor
